// ==== design/bpi_regs.vh ====
// register map, field positions, reset values and timing counts
// included by the button/power event interrupt block; definitions only
`ifndef BPI_REGS_VH
`define BPI_REGS_VH

// register offsets (8-bit address space)
`define BPI_ADDR_BTN_STATUS 8'h24
`define BPI_ADDR_BTN_MASK 8'h25
`define BPI_ADDR_BTN_SENSE 8'h26
`define BPI_ADDR_MISC_STATUS 8'h28
`define BPI_ADDR_MISC_MASK 8'h29
`define BPI_ADDR_MISC_SENSE 8'h2a

// button group field positions
`define BPI_BIT_PUSH 0
`define BPI_BIT_HOLD1 1
`define BPI_BIT_HOLD2 2
`define BPI_BIT_HOLD3 3
`define BPI_BIT_HOLD4 4
`define BPI_BIT_HOLD8 5

// misc group field positions
`define BPI_BIT_POWERUP 0
`define BPI_BIT_POWERDOWN 1
`define BPI_BIT_POWERON 2
`define BPI_BIT_LOW_WARN 3
`define BPI_BIT_OVERVOLT 4

// reset values
`define BPI_RST_BTN_MASK 6'h3f
`define BPI_RST_MISC_MASK 5'h1f
`define BPI_RST_STATUS 8'h00

// hold thresholds in seconds and clock rate
`define BPI_CLK_HZ 25000000
`define BPI_HOLD1_S 1
`define BPI_HOLD2_S 2
`define BPI_HOLD3_S 3
`define BPI_HOLD4_S 4
`define BPI_HOLD8_S 8
`define BPI_HOLD1_CYC (`BPI_HOLD1_S * `BPI_CLK_HZ)
`define BPI_HOLD2_CYC (`BPI_HOLD2_S * `BPI_CLK_HZ)
`define BPI_HOLD3_CYC (`BPI_HOLD3_S * `BPI_CLK_HZ)
`define BPI_HOLD4_CYC (`BPI_HOLD4_S * `BPI_CLK_HZ)
`define BPI_HOLD8_CYC (`BPI_HOLD8_S * `BPI_CLK_HZ)

`endif

// ==== design/bpi_hold_timer.v ====
// hold-duration timer for the debounced power button level
// assumes push_level is a synchronised, already debounced level on clk
`timescale 1ns/100ps
`default_nettype none
module bpi_hold_timer #(
  parameter [31:0] HOLD1_CYC = 32'd25000000,
  parameter [31:0] HOLD2_CYC = 32'd50000000,
  parameter [31:0] HOLD3_CYC = 32'd75000000,
  parameter [31:0] HOLD4_CYC = 32'd100000000,
  parameter [31:0] HOLD8_CYC = 32'd200000000
) (
  input wire clk,
  input wire rst_n,
  input wire push_level,
  output reg [4:0] hold_sense
);
  reg [31:0] count;

  // count while held, saturating at the longest threshold
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h00000000;
    end else if (!push_level) begin
      count <= 32'h00000000;
    end else if (count < HOLD8_CYC) begin
      count <= count + 32'h00000001;
    end
  end

  // sense bits set past each threshold, cleared on release
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_sense <= 5'h00;
    end else if (!push_level) begin
      hold_sense <= 5'h00;
    end else begin
      hold_sense <= {count >= HOLD8_CYC, count >= HOLD4_CYC, count >= HOLD3_CYC,
                     count >= HOLD2_CYC, count >= HOLD1_CYC};
    end
  end
endmodule
`default_nettype wire

// ==== design/bpi_event_irq.v ====
// power button and miscellaneous power event interrupt block
// assumes a simple synchronous register port from the host interface logic,
// asynchronous event and level inputs from analog/sequencer blocks
//
// Notes on behaviour
// - hold3 mask bit 3, reset 1; 0 lets hold3 status assert interrupt
// - hold4 mask bit 4, reset 1; 0 lets hold4 status assert interrupt
// - hold8 mask bit 5, reset 1; 0 lets hold8 status assert interrupt
// - push sense bit 0 follows debounced button level, resets 0
// - hold1 sense bit 1 set after 1 s held, cleared on release
// - hold2 sense bit 2 set after 2 s held, cleared on release
// - hold3 sense bit 3 set after 3 s held, cleared on release
// - hold4 sense bit 4 set after 4 s held, cleared on release
// - hold8 sense bit 5 set after 8 s held, cleared on release
// - sticky powerup-done status bit 0 on completed transition to run
// - sticky powerdown-done status bit 1 on completed transition from run
// - sticky power-on event status bit 2 on each power-on event
// - sticky low-voltage warning status bit 3 on threshold crossing
// - sticky overvoltage status bit 4 on threshold crossing
// - misc status bits clear on read or write-1; writing 0 keeps them
// - powerup-done mask bit 0, reset 1, 0 enables interrupt
// - powerdown-done mask bit 1, reset 1, 0 enables interrupt
// - power-on event mask bit 2, reset 1, gates its interrupt, not its status
// - push status set on every push sense change, press and release
// - low-voltage and overvoltage masks at bits 3 and 4, reset 1
`timescale 1ns/100ps
`default_nettype none
`include "bpi_regs.vh"
module bpi_event_irq #(
  parameter [31:0] HOLD1_CYC = `BPI_HOLD1_CYC,
  parameter [31:0] HOLD2_CYC = `BPI_HOLD2_CYC,
  parameter [31:0] HOLD3_CYC = `BPI_HOLD3_CYC,
  parameter [31:0] HOLD4_CYC = `BPI_HOLD4_CYC,
  parameter [31:0] HOLD8_CYC = `BPI_HOLD8_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire reg_rd,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire power_button_pressed,
  input wire powerup_done,
  input wire powerdown_done,
  input wire poweron_level,
  input wire sys_low_warn_level,
  input wire sys_overvolt_level,
  output reg irq_out_n
);
  // two-flop synchronisers for asynchronous inputs
  reg [5:0] sync1;
  reg [5:0] sync2;
  // previous synchronised values for edge detection
  reg [5:0] prev;
  reg [5:0] btn_status;
  reg [5:0] btn_mask;
  reg [4:0] misc_status;
  reg [4:0] misc_mask;
  reg [5:0] next_btn_status;
  reg [4:0] next_misc_status;
  reg [7:0] next_rdata;
  wire [4:0] hold_sense;
  wire push_level;
  wire [5:0] btn_sense;
  wire [4:0] misc_sense;
  wire [5:0] btn_set;
  wire [4:0] misc_set;
  wire any_irq;
  // last hold sense, for rising-edge detection of the hold statuses
  reg [4:0] hold_sense_q;
  // named sense fields of the button group
  wire push_sense;
  wire hold1_sense;
  wire hold2_sense;
  wire hold3_sense;
  wire hold4_sense;
  wire hold8_sense;
  // named mask fields that gate the interrupt pin
  wire hold3_mask;
  wire hold4_mask;
  wire hold8_mask;
  wire powerup_done_mask;
  wire powerdown_done_mask;
  wire poweron_event_mask;
  wire sys_low_warn_mask;
  wire sys_overvolt_mask;
  // decoded register accesses
  wire rd_btn_status;
  wire wr_btn_status;
  wire rd_misc_status;
  wire wr_misc_status;
  wire wr_btn_mask;
  wire wr_misc_mask;
  // per-source requests: next status set and mask removed
  wire [5:0] btn_req;
  wire [4:0] misc_req;

  // true when a read or write hits the given address
  function hit;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = strobe && (addr == target);
    end
  endfunction

  // synchronise button and event inputs before any logic reads them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      prev <= 6'h00;
    end else begin
      sync1 <= {sys_overvolt_level, sys_low_warn_level, poweron_level,
                powerdown_done, powerup_done, power_button_pressed};
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  assign push_level = sync2[0];

  // hold timer drives the duration sense bits
  bpi_hold_timer #(
    .HOLD1_CYC(HOLD1_CYC),
    .HOLD2_CYC(HOLD2_CYC),
    .HOLD3_CYC(HOLD3_CYC),
    .HOLD4_CYC(HOLD4_CYC),
    .HOLD8_CYC(HOLD8_CYC)
  ) u_hold (
    .clk(clk),
    .rst_n(rst_n),
    .push_level(push_level),
    .hold_sense(hold_sense)
  );

  // push sense follows the debounced level
  assign push_sense = push_level;
  assign hold1_sense = hold_sense[0];
  assign hold2_sense = hold_sense[1];
  assign hold3_sense = hold_sense[2];
  assign hold4_sense = hold_sense[3];
  assign hold8_sense = hold_sense[4];
  // sense registers as the host reads them
  assign btn_sense = {hold8_sense, hold4_sense, hold3_sense,
                      hold2_sense, hold1_sense, push_sense};
  assign misc_sense = sync2[5:1];

  assign btn_set[`BPI_BIT_PUSH] = push_level ^ prev[0];
  // hold statuses on rising edge of each hold sense
  assign btn_set[5:1] = hold_sense & ~hold_sense_q;

  // sense delayed one clock; both reset to 0, so no false edge after reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_sense_q <= 5'h00;
    end else begin
      hold_sense_q <= hold_sense;
    end
  end

  assign misc_set[`BPI_BIT_POWERUP] = sync2[1] & ~prev[1];
  assign misc_set[`BPI_BIT_POWERDOWN] = sync2[2] & ~prev[2];
  assign misc_set[`BPI_BIT_POWERON] = sync2[3] & ~prev[3];
  assign misc_set[`BPI_BIT_LOW_WARN] = sync2[4] ^ prev[4];
  assign misc_set[`BPI_BIT_OVERVOLT] = sync2[5] ^ prev[5];

  // register access decode, shared by status and mask logic
  assign rd_btn_status = hit(reg_rd, reg_addr, `BPI_ADDR_BTN_STATUS);
  assign wr_btn_status = hit(reg_wr, reg_addr, `BPI_ADDR_BTN_STATUS);
  // read and write strobes on misc status
  assign rd_misc_status = hit(reg_rd, reg_addr, `BPI_ADDR_MISC_STATUS);
  assign wr_misc_status = hit(reg_wr, reg_addr, `BPI_ADDR_MISC_STATUS);
  // mask writes
  assign wr_btn_mask = hit(reg_wr, reg_addr, `BPI_ADDR_BTN_MASK);
  assign wr_misc_mask = hit(reg_wr, reg_addr, `BPI_ADDR_MISC_MASK);

  // sticky status: clear by read or write-1, new events win over clear
  always @* begin
    next_btn_status = btn_status;
    next_misc_status = misc_status;
    if (rd_btn_status) begin
      next_btn_status = 6'h00;
    end
    // a write-1 in the same cycle as a read keeps the write result
    if (wr_btn_status) begin
      next_btn_status = btn_status & ~reg_wdata[5:0];
    end
    if (rd_misc_status) begin
      next_misc_status = 5'h00;
    end
    if (wr_misc_status) begin
      next_misc_status = misc_status & ~reg_wdata[4:0];
    end
    // events win over a clear in the same cycle
    next_btn_status = next_btn_status | btn_set;
    next_misc_status = next_misc_status | misc_set;
  end

  // status and mask registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_status <= 6'h00;
      misc_status <= 5'h00;
      btn_mask <= `BPI_RST_BTN_MASK;
      misc_mask <= `BPI_RST_MISC_MASK;
    end else begin
      btn_status <= next_btn_status;
      misc_status <= next_misc_status;
      if (wr_btn_mask) begin
        btn_mask <= reg_wdata[5:0];
      end
      if (wr_misc_mask) begin
        misc_mask <= reg_wdata[4:0];
      end
    end
  end

  // read data mux; unused bits and unmapped addresses read zero
  always @* begin
    case (reg_addr)
      `BPI_ADDR_BTN_STATUS: next_rdata = {2'h0, btn_status};
      `BPI_ADDR_BTN_MASK: next_rdata = {2'h0, btn_mask};
      `BPI_ADDR_BTN_SENSE: next_rdata = {2'h0, btn_sense};
      `BPI_ADDR_MISC_STATUS: next_rdata = {3'h0, misc_status};
      `BPI_ADDR_MISC_MASK: next_rdata = {3'h0, misc_mask};
      `BPI_ADDR_MISC_SENSE: next_rdata = {3'h0, misc_sense};
      default: next_rdata = 8'h00;
    endcase
  end

  // named mask fields; a set mask blocks the pin, never the status
  assign hold3_mask = btn_mask[`BPI_BIT_HOLD3];
  assign hold4_mask = btn_mask[`BPI_BIT_HOLD4];
  assign hold8_mask = btn_mask[`BPI_BIT_HOLD8];
  assign powerup_done_mask = misc_mask[`BPI_BIT_POWERUP];
  assign powerdown_done_mask = misc_mask[`BPI_BIT_POWERDOWN];
  assign poweron_event_mask = misc_mask[`BPI_BIT_POWERON];
  assign sys_low_warn_mask = misc_mask[`BPI_BIT_LOW_WARN];
  assign sys_overvolt_mask = misc_mask[`BPI_BIT_OVERVOLT];

  // requests use the next status, so the pin moves with the status
  // lower button sources keep their own mask bits
  assign btn_req[`BPI_BIT_PUSH] = next_btn_status[`BPI_BIT_PUSH] & ~btn_mask[`BPI_BIT_PUSH];
  assign btn_req[`BPI_BIT_HOLD1] = next_btn_status[`BPI_BIT_HOLD1] & ~btn_mask[`BPI_BIT_HOLD1];
  assign btn_req[`BPI_BIT_HOLD2] = next_btn_status[`BPI_BIT_HOLD2] & ~btn_mask[`BPI_BIT_HOLD2];
  assign btn_req[`BPI_BIT_HOLD3] = next_btn_status[`BPI_BIT_HOLD3] & ~hold3_mask;
  assign btn_req[`BPI_BIT_HOLD4] = next_btn_status[`BPI_BIT_HOLD4] & ~hold4_mask;
  assign btn_req[`BPI_BIT_HOLD8] = next_btn_status[`BPI_BIT_HOLD8] & ~hold8_mask;
  assign misc_req[`BPI_BIT_POWERUP] =
    next_misc_status[`BPI_BIT_POWERUP] & ~powerup_done_mask;
  assign misc_req[`BPI_BIT_POWERDOWN] =
    next_misc_status[`BPI_BIT_POWERDOWN] & ~powerdown_done_mask;
  assign misc_req[`BPI_BIT_POWERON] =
    next_misc_status[`BPI_BIT_POWERON] & ~poweron_event_mask;
  assign misc_req[`BPI_BIT_LOW_WARN] =
    next_misc_status[`BPI_BIT_LOW_WARN] & ~sys_low_warn_mask;
  assign misc_req[`BPI_BIT_OVERVOLT] =
    next_misc_status[`BPI_BIT_OVERVOLT] & ~sys_overvolt_mask;

  // any unmasked source pulls interrupt low
  assign any_irq = (|btn_req) | (|misc_req);

  // registered outputs: read data captured on read strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      irq_out_n <= 1'b1;
    end else begin
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
      irq_out_n <= ~any_irq;
    end
  end
endmodule
`default_nettype wire

// ==== dv/bpi_host.sv ====
// host register port model: one-cycle read and write strobes
// assumes the bench clock; drives 1 ns after each rising edge
`timescale 1ns/100ps
`default_nettype none
module bpi_host (
  input wire clk,
  input wire [7:0] reg_rdata,
  output logic reg_rd = 1'b0,
  output logic reg_wr = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk) #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ==== dv/bpi_monitor.sv ====
// port checker for the event interrupt block
// bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none
module bpi_monitor (
  input wire clk,
  input wire rst_n,
  input wire reg_rd,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire power_button_pressed,
  input wire irq_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // read port, sense and mask relations
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  property p_unmap; reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'h00; endproperty
  property p_press; power_button_pressed[*5] ##0 (reg_rd && reg_addr == 8'h26)
    |=> reg_rdata[0]; endproperty
  property p_rel; !power_button_pressed[*5] ##0 (reg_rd && reg_addr == 8'h26)
    |=> reg_rdata == 8'h00; endproperty
  property p_mw; reg_rd && reg_addr == 8'h29 |=> reg_rdata[7:5] == 3'h0; endproperty
  property p_sw; reg_rd && reg_addr == 8'h28 |=> reg_rdata[7:5] == 3'h0; endproperty
  property p_bw; reg_rd && reg_addr == 8'h26 |=> reg_rdata[7:6] == 2'h0; endproperty
  property p_mask; (reg_wr && reg_addr == 8'h29 && reg_wdata[4:0] == 5'h1f) ##2
    (reg_wr && reg_addr == 8'h25 && reg_wdata[5:0] == 6'h3f) |=> ##1 irq_out_n; endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_press: assert property (p_press) else $error("push sense low");
  a_rel: assert property (p_rel) else $error("sense not cleared");
  a_mw: assert property (p_mw) else $error("mask width");
  a_sw: assert property (p_sw) else $error("status width");
  a_bw: assert property (p_bw) else $error("sense width");
  a_mask: assert property (p_mask) else $error("irq when masked");
  c_irq: cover property ($fell(irq_out_n));
  c_held: cover property (power_button_pressed[*8]);
  c_rd: cover property (reg_rd && reg_addr == 8'h28);
endmodule
bind bpi_event_irq bpi_monitor u_mon (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .power_button_pressed(power_button_pressed), .irq_out_n(irq_out_n));
`default_nettype wire

// ==== dv/tb_button_and_power_event_irq.sv ====
// self-checking bench for the event interrupt block
// assumes short hold counts of 10, 20, 30, 40 and 80 cycles
`timescale 1ns/100ps
`default_nettype none
module tb_button_and_power_event_irq;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic btn = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [7:0] d;
  wire reg_rd, reg_wr, irq_out_n;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  int n_errors = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  bpi_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  bpi_event_irq #(.HOLD1_CYC(32'd10), .HOLD2_CYC(32'd20), .HOLD3_CYC(32'd30),
    .HOLD4_CYC(32'd40), .HOLD8_CYC(32'd80)) dut (.clk(clk), .rst_n(rst_n),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .power_button_pressed(btn), .powerup_done(ev[0]),
    .powerdown_done(ev[1]), .poweron_level(ev[2]), .sys_low_warn_level(ev[3]),
    .sys_overvolt_level(ev[4]), .irq_out_n(irq_out_n));
  // compare and count
  task chk(input string w, input [7:0] e, input [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task rchk(input [7:0] a, input [7:0] e);
    host.rd(a, d);
    chk($sformatf("reg_%h", a), e, d);
  endtask
  task ichk(input e);
    #1 chk("irq_out_n", {7'h0, e}, {7'h0, irq_out_n}); // sampled after the edge settles
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    n_errors++;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    rchk(8'h25, 8'h3f);
    rchk(8'h29, 8'h1f);
    rchk(8'h28, 8'h00);
    rchk(8'h26, 8'h00);
    rchk(8'h30, 8'h00);
    ichk(1'b1);
    host.wr(8'h29, 8'h00);
    rchk(8'h29, 8'h00);
    // each misc event in turn
    for (int i = 0; i < 5; i++) begin
      ev[i] = 1'b1;
      repeat (6) @(posedge clk);
      ichk(1'b0);
      rchk(8'h28, 8'h01 << i);
      rchk(8'h28, 8'h00);
    end
    ev = 5'h00;
    repeat (6) @(posedge clk);
    host.wr(8'h28, 8'h00);
    host.wr(8'h28, 8'h08);
    rchk(8'h28, 8'h10);
    rchk(8'h28, 8'h00);
    host.wr(8'h29, 8'h1f);
    host.wr(8'h25, 8'h3f);
    ev[0] = 1'b1;
    repeat (6) @(posedge clk);
    ichk(1'b1);
    rchk(8'h28, 8'h01);
    rchk(8'h2a, 8'h01);
    host.wr(8'h25, 8'h00);
    btn = 1'b1;
    repeat (35) @(posedge clk);
    rchk(8'h26, 8'h0f);
    repeat (60) @(posedge clk);
    rchk(8'h26, 8'h3f);
    ichk(1'b0);
    rchk(8'h24, 8'h3f);
    btn = 1'b0;
    repeat (6) @(posedge clk);
    rchk(8'h26, 8'h00);
    rchk(8'h24, 8'h01);
    repeat (2) @(posedge clk);
    ichk(1'b1);
    end_of_test;
  end
endmodule
`default_nettype wire
